// >>> inc/shifter_pkg.sv
// Shared constants and types of the barrel shifter datapath
package shifter_pkg;

  localparam int DATA_W    = 16;
  localparam int RES_W     = 32;
  localparam int SE_W      = 8;
  localparam int SB_W      = 5;
  localparam int CODE_W    = 8;
  localparam int BANK_N    = 2;

  localparam logic              PRIMARY_BANK = 1'b0;
  localparam logic [DATA_W-1:0] SI_RESET     = 16'h0000;
  localparam logic [SE_W-1:0]   SE_RESET     = 8'h00;
  localparam logic [SB_W-1:0]   SB_RESET     = 5'h00;
  localparam logic [DATA_W-1:0] SR_RESET     = 16'h0000;

  typedef enum logic [2:0] {
    REG_SI, REG_SE, REG_SB, REG_SR0, REG_SR1
  } reg_sel_t;

  typedef enum logic [1:0] {
    OP_NONE, OP_SHIFT, OP_EXP, OP_BLOCK_EXP
  } op_kind_t;

  typedef enum logic [1:0] {
    CODE_SE, CODE_NEG_SE, CODE_IMM
  } code_src_t;

  typedef enum logic [1:0] {
    EXT_MSB, EXT_CARRY, EXT_ZERO
  } ext_src_t;

  typedef enum logic {
    SRC_INPUT, SRC_RBUS
  } operand_src_t;

  // One operation as issued by the instruction decoder
  typedef struct packed {
    op_kind_t           op;
    operand_src_t       src;
    code_src_t          code_src;
    logic [CODE_W-1:0]  imm;
    logic               reference_half_select;
    ext_src_t           ext_src;
    logic               or_with_result_option;
  } shift_cmd_t;

  // One complete register bank
  typedef struct packed {
    logic [DATA_W-1:0]  shifter_input;
    logic [SE_W-1:0]    shift_exponent;
    logic [SB_W-1:0]    block_exponent;
    logic [DATA_W-1:0]  shift_result_high;
    logic [DATA_W-1:0]  shift_result_low;
  } bank_regs_t;

  localparam bank_regs_t BANK_RESET = '{SI_RESET, SE_RESET, SB_RESET, SR_RESET, SR_RESET};

endpackage : shifter_pkg

// >>> design/shift_array.sv
// Placement array: puts a word anywhere in a double-width field
`timescale 1ns/100ps
module shift_array #(
  parameter int IN_W   = 16,
  parameter int OUT_W  = 32,
  parameter int CODE_W = 8
) (
  input  wire logic [IN_W-1:0]   operand,
  input  wire logic [CODE_W-1:0] code,
  input  wire logic              high_ref,
  input  wire logic              ext_bit,
  output logic      [OUT_W-1:0]  placed
);
  localparam int POS_W = CODE_W + 2;
  localparam int SEL_W = $clog2(IN_W);

  if (OUT_W != 2 * IN_W) begin : g_bad_width
    $error("shift_array: output must be twice the input width");
  end

  wire signed [POS_W-1:0] code_ext = $signed({{2{code[CODE_W-1]}}, code});
  wire signed [POS_W-1:0] ref_off  = high_ref ? POS_W'(IN_W) : POS_W'(0);
  wire signed [POS_W-1:0] pos      = code_ext + ref_off;

  // Each output bit looks back to the input bit that lands on it
  for (genvar b = 0; b < OUT_W; b++) begin : g_bit
    wire signed [POS_W-1:0] src = POS_W'(b) - pos;
    assign placed[b] = (src < 0) ? 1'b0 :
                       (src >= POS_W'(IN_W)) ? ext_bit :
                       operand[src[SEL_W-1:0]];
  end

endmodule : shift_array

// >>> design/exp_detect.sv
// Exponent detector, single-precision high mode
`timescale 1ns/100ps
module exp_detect #(
  parameter int IN_W  = 16,
  parameter int EXP_W = 8
) (
  input  wire logic [IN_W-1:0]  operand,
  output logic      [EXP_W-1:0] exponent
);
  if (IN_W >= 2 ** (EXP_W - 1)) begin : g_bad_width
    $error("exp_detect: exponent too narrow for input");
  end

  logic [EXP_W-1:0] redundant;
  logic             done;

  // Counts sign copies below the sign bit
  always_comb begin
    redundant = '0;
    done      = 1'b0;
    for (int i = IN_W - 2; i >= 0; i--) begin
      if (!done && operand[i] == operand[IN_W-1]) begin
        redundant = redundant + EXP_W'(1);
      end else begin
        done = 1'b1;
      end
    end
    exponent = ~redundant + EXP_W'(1);
  end

endmodule : exp_detect

// >>> design/dsp_barrel_shifter.sv
// Barrel shifter datapath with dual register bank
`timescale 1ns/100ps
module dsp_barrel_shifter (
  input  wire logic                            CORE_CLK,
  input  wire logic                            NRST,
  input  wire logic [shifter_pkg::DATA_W-1:0]  DMD_IN,
  input  wire shifter_pkg::reg_sel_t           DMD_ADDR,
  input  wire logic                            DMD_WR,
  input  wire logic                            DMD_RD,
  output logic      [shifter_pkg::DATA_W-1:0]  DMD_OUT,
  output logic                                 DMD_OE,
  input  wire logic [shifter_pkg::DATA_W-1:0]  R_BUS_IN,
  input  wire logic                            R_BUS_RD,
  input  wire logic                            R_BUS_HIGH,
  output logic      [shifter_pkg::DATA_W-1:0]  R_BUS_OUT,
  output logic                                 R_BUS_OE,
  input  wire shifter_pkg::shift_cmd_t         CMD,
  input  wire logic                            ALU_CARRY,
  input  wire logic                            MODE_STATUS_REGISTER_BANK,
  input  wire logic                            ENA_SEC,
  input  wire logic                            DIS_SEC,
  output logic                                 BANK_ALT
);

  localparam int DW = shifter_pkg::DATA_W;
  localparam int RW = shifter_pkg::RES_W;
  localparam int EW = shifter_pkg::SE_W;
  localparam int BW = shifter_pkg::SB_W;
  localparam int CW = shifter_pkg::CODE_W;

  shifter_pkg::bank_regs_t regs [shifter_pkg::BANK_N];
  shifter_pkg::bank_regs_t cur;
  shifter_pkg::bank_regs_t next_regs;

  logic           mode_status_register_q;
  logic           next_bank;
  logic [DW-1:0]  operand;
  logic [CW-1:0]  code_sel;
  logic           ext_bit;
  logic [RW-1:0]  placed;
  logic [RW-1:0]  sr_full;
  logic [RW-1:0]  next_sr;
  logic [EW-1:0]  exp_code;
  logic [BW-1:0]  exp_short;
  logic [BW-1:0]  next_sb;
  logic [DW-1:0]  dmd_rd_val;
  logic [DW-1:0]  rbus_rd_val;
  logic [DW-1:0]  cur_si;
  logic [EW-1:0]  cur_se;
  logic [BW-1:0]  cur_sb;
  logic [DW-1:0]  idle_si;
  logic           do_shift;
  logic           do_exp;
  logic           do_block;
  logic           bank_flip;
  logic           sr_write;
  logic           se_write;

  // Active bank view
  assign cur     = regs[BANK_ALT];
  assign cur_si  = cur.shifter_input;
  assign cur_se  = cur.shift_exponent;
  assign cur_sb  = cur.block_exponent;
  assign idle_si = regs[~BANK_ALT].shifter_input;
  assign sr_full = {cur.shift_result_high, cur.shift_result_low};

  // Operation decode
  assign do_shift = CMD.op == shifter_pkg::OP_SHIFT;
  assign do_exp   = CMD.op == shifter_pkg::OP_EXP;
  assign do_block = CMD.op == shifter_pkg::OP_BLOCK_EXP;
  assign sr_write = DMD_WR && (DMD_ADDR == shifter_pkg::REG_SR0 ||
                               DMD_ADDR == shifter_pkg::REG_SR1);
  assign se_write = DMD_WR && DMD_ADDR == shifter_pkg::REG_SE;

  // Operand selection
  assign operand = (CMD.src == shifter_pkg::SRC_RBUS) ? R_BUS_IN
                                                      : cur_si;

  // Control code selection
  assign code_sel = (CMD.code_src == shifter_pkg::CODE_IMM)    ? CMD.imm :
                    (CMD.code_src == shifter_pkg::CODE_NEG_SE) ? ~cur_se + 8'h01 :
                    cur_se;

  // Extension bit source
  assign ext_bit = (CMD.ext_src == shifter_pkg::EXT_MSB)   ? operand[DW-1] :
                   (CMD.ext_src == shifter_pkg::EXT_CARRY) ? ALU_CARRY :
                   1'b0;

  shift_array #(
    .IN_W   (DW),
    .OUT_W  (RW),
    .CODE_W (CW)
  ) u_array (
    .operand  (operand),
    .code     (code_sel),
    .high_ref (CMD.reference_half_select),
    .ext_bit  (ext_bit),
    .placed   (placed)
  );

  exp_detect #(
    .IN_W  (DW),
    .EXP_W (EW)
  ) u_exp (
    .operand  (operand),
    .exponent (exp_code)
  );

  // OR/pass combining
  assign next_sr = CMD.or_with_result_option ? (sr_full | placed) : placed;

  // Block exponent keeps the largest signed exponent seen
  assign exp_short = exp_code[BW-1:0];
  assign next_sb   = ($signed(exp_short) > $signed(cur_sb)) ? exp_short : cur_sb;

  // Next contents of the active bank; memory-bus loads win over results
  always_comb begin
    next_regs = cur;
    if (do_shift) begin
      {next_regs.shift_result_high, next_regs.shift_result_low} = next_sr;
    end
    if (do_exp) begin
      next_regs.shift_exponent = exp_code;
    end
    if (do_block) begin
      next_regs.block_exponent = next_sb;
    end
    if (DMD_WR) begin
      case (DMD_ADDR)
        shifter_pkg::REG_SI:  next_regs.shifter_input     = DMD_IN;
        shifter_pkg::REG_SE:  next_regs.shift_exponent    = DMD_IN[EW-1:0];
        shifter_pkg::REG_SB:  next_regs.block_exponent    = DMD_IN[BW-1:0];
        shifter_pkg::REG_SR0: next_regs.shift_result_low  = DMD_IN;
        shifter_pkg::REG_SR1: next_regs.shift_result_high = DMD_IN;
        default:              next_regs.shifter_input     = cur_si;
      endcase
    end
  end

  // Read data from the pre-update contents
  assign dmd_rd_val =
    (DMD_ADDR == shifter_pkg::REG_SI)  ? cur_si :
    (DMD_ADDR == shifter_pkg::REG_SE)  ? {{(DW-EW){cur_se[EW-1]}}, cur_se} :
    (DMD_ADDR == shifter_pkg::REG_SB)  ? {{(DW-BW){cur_sb[BW-1]}}, cur_sb} :
    (DMD_ADDR == shifter_pkg::REG_SR0) ? cur.shift_result_low :
    (DMD_ADDR == shifter_pkg::REG_SR1) ? cur.shift_result_high :
    16'h0000;
  assign rbus_rd_val = R_BUS_HIGH ? cur.shift_result_high : cur.shift_result_low;

  // Bank choice: instructions first, then a change of the mode bit
  assign next_bank = ENA_SEC ? 1'b1 :
                     DIS_SEC ? 1'b0 :
                     (MODE_STATUS_REGISTER_BANK != mode_status_register_q) ? MODE_STATUS_REGISTER_BANK : BANK_ALT;
  assign bank_flip = next_bank != BANK_ALT;

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      BANK_ALT <= shifter_pkg::PRIMARY_BANK;
      mode_status_register_q  <= 1'b0;
    end else begin
      BANK_ALT <= next_bank;
      mode_status_register_q  <= MODE_STATUS_REGISTER_BANK;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      regs <= '{default: shifter_pkg::BANK_RESET};
    end else begin
      regs[BANK_ALT] <= next_regs;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      DMD_OUT   <= 16'h0000;
      DMD_OE    <= 1'b0;
      R_BUS_OUT <= 16'h0000;
      R_BUS_OE  <= 1'b0;
    end else begin
      DMD_OUT   <= DMD_RD ? dmd_rd_val : 16'h0000;
      DMD_OE    <= DMD_RD;
      R_BUS_OUT <= R_BUS_RD ? rbus_rd_val : 16'h0000;
      R_BUS_OE  <= R_BUS_RD;
    end
  end

  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  property p_reset_primary;
    $rose(NRST) |-> !BANK_ALT;
  endproperty
  a_reset_primary: assert property (p_reset_primary)
    else $error("bank not primary after reset");

  property p_ena_sec;
    ENA_SEC |=> BANK_ALT;
  endproperty
  a_ena_sec: assert property (p_ena_sec)
    else $error("enable-secondary did not select alternate bank");

  property p_dis_sec;
    DIS_SEC && !ENA_SEC |=> !BANK_ALT;
  endproperty
  a_dis_sec: assert property (p_dis_sec)
    else $error("disable-secondary did not select primary bank");

  property p_mode_bit;
    MODE_STATUS_REGISTER_BANK != mode_status_register_q && !ENA_SEC && !DIS_SEC |=> BANK_ALT == $past(MODE_STATUS_REGISTER_BANK);
  endproperty
  a_mode_bit: assert property (p_mode_bit)
    else $error("bank does not follow mode bit");

  property p_bank_isolated;
    DMD_WR && !bank_flip |=> $stable(idle_si);
  endproperty
  a_bank_isolated: assert property (p_bank_isolated)
    else $error("write reached the inactive bank");

  property p_se_sign_ext;
    DMD_RD && DMD_ADDR == shifter_pkg::REG_SE |=> DMD_OE && DMD_OUT[15:8] == {8{DMD_OUT[7]}};
  endproperty
  a_se_sign_ext: assert property (p_se_sign_ext)
    else $error("shift exponent read not sign extended");

  property p_sb_sign_ext;
    DMD_RD && DMD_ADDR == shifter_pkg::REG_SB
      |=> DMD_OUT[15:4] == 12'h000 || DMD_OUT[15:4] == 12'hFFF;
  endproperty
  a_sb_sign_ext: assert property (p_sb_sign_ext)
    else $error("block exponent read not sign extended");

  property p_read_old;
    DMD_RD && DMD_WR && DMD_ADDR == shifter_pkg::REG_SI && DMD_IN != cur_si
      |=> DMD_OUT == $past(cur_si);
  endproperty
  a_read_old: assert property (p_read_old)
    else $error("same-cycle read returned new value");

  property p_rbus_high;
    R_BUS_RD && R_BUS_HIGH |=> R_BUS_OE && R_BUS_OUT == $past(cur.shift_result_high);
  endproperty
  a_rbus_high: assert property (p_rbus_high)
    else $error("result bus high half mismatch");

  property p_pass;
    do_shift && !CMD.or_with_result_option && !sr_write && !bank_flip
      |=> sr_full == $past(placed);
  endproperty
  a_pass: assert property (p_pass)
    else $error("pass result not loaded unchanged");

  property p_or_keeps;
    do_shift && CMD.or_with_result_option && !sr_write && !bank_flip
      |=> (sr_full & $past(sr_full)) == $past(sr_full);
  endproperty
  a_or_keeps: assert property (p_or_keeps)
    else $error("OR option lost result bits");

  property p_hi_ref;
    do_shift && CMD.reference_half_select && code_sel == 8'h00 &&
    !CMD.or_with_result_option && !sr_write && !bank_flip
      |=> cur.shift_result_high == $past(operand) && cur.shift_result_low == 16'h0000;
  endproperty
  a_hi_ref: assert property (p_hi_ref)
    else $error("high reference placement wrong");

  property p_off_right;
    do_shift && code_sel == 8'h80 && !CMD.or_with_result_option && !sr_write && !bank_flip
      |=> sr_full == {RW{$past(ext_bit)}};
  endproperty
  a_off_right: assert property (p_off_right)
    else $error("off-scale right placement not all extension bits");

  property p_exp_norm;
    do_exp && !se_write && !bank_flip
      |=> (cur_se == 8'h00) == $past(operand[15] ^ operand[14]) &&
          $signed(cur_se) >= -8'sd15 && $signed(cur_se) <= 8'sd0;
  endproperty
  a_exp_norm: assert property (p_exp_norm)
    else $error("derived exponent wrong");

  property p_block_max;
    do_block && !(DMD_WR && DMD_ADDR == shifter_pkg::REG_SB) && !bank_flip
      |=> $signed(cur_sb) >= $signed($past(cur_sb));
  endproperty
  a_block_max: assert property (p_block_max)
    else $error("block exponent decreased");

  property p_c_or_shift;
    do_shift && CMD.or_with_result_option;
  endproperty
  c_or_shift: cover property (p_c_or_shift);

  property p_c_alt_bank;
    ENA_SEC ##1 DMD_WR;
  endproperty
  c_alt_bank: cover property (p_c_alt_bank);

  property p_c_exp_then_shift;
    do_exp ##1 do_shift && CMD.code_src == shifter_pkg::CODE_NEG_SE;
  endproperty
  c_exp_then_shift: cover property (p_c_exp_then_shift);

  property p_c_block;
    do_block ##1 do_block;
  endproperty
  c_block: cover property (p_c_block);

endmodule : dsp_barrel_shifter

// >>> verif/core_partner.sv
// Result bus source standing in for the core's other units
`timescale 1ns/100ps
module core_partner (
  input  wire logic                           clk,
  input  wire logic                           nrst,
  input  wire logic                           drive,
  input  wire logic [shifter_pkg::DATA_W-1:0] value,
  output logic      [shifter_pkg::DATA_W-1:0] r_bus
);
  logic [shifter_pkg::DATA_W-1:0] idle_pattern;

  // Undriven bus steps from 16'h5A5A to 16'hFFFF in five cycles after reset, then holds 16'hFFFF
  always_ff @(posedge clk) begin
    if (!nrst)
      idle_pattern <= 16'h5A5A;
    else
      idle_pattern <= ~idle_pattern ^ {idle_pattern[14:0], idle_pattern[15]};
  end

  assign r_bus = drive ? value : idle_pattern;
endmodule : core_partner

// >>> verif/dsp_barrel_shifter_bench.sv
// Self-checking bench of the barrel shifter datapath
`timescale 1ns/100ps
module dsp_barrel_shifter_bench;
  logic                           clk;
  logic                           nrst;
  logic [shifter_pkg::DATA_W-1:0] dmd_in;
  shifter_pkg::reg_sel_t          dmd_addr;
  logic                           dmd_wr;
  logic                           dmd_rd;
  logic [shifter_pkg::DATA_W-1:0] dmd_out;
  logic                           dmd_oe;
  logic [shifter_pkg::DATA_W-1:0] r_bus_in;
  logic                           r_bus_rd;
  logic                           r_bus_high;
  logic [shifter_pkg::DATA_W-1:0] r_bus_out;
  logic                           r_bus_oe;
  shifter_pkg::shift_cmd_t        cmd;
  logic                           alu_carry;
  logic                           mode_status_register_bank;
  logic                           ena_sec;
  logic                           dis_sec;
  logic                           bank_alt;
  logic                           rb_drive;
  logic [shifter_pkg::DATA_W-1:0] rb_value;
  logic [31:0]                    seed;
  int                             err_total;
  int                             checked;
  int                             cycles;

  localparam logic [7:0]  CORNER [8] = '{8'h80, 8'hE0, 8'hEF, 8'hF0, 8'h00, 8'h10, 8'h20, 8'h7F};
  localparam logic [15:0] ECORNER [5] = '{16'h0000, 16'hFFFF, 16'h0001, 16'h8000, 16'h7FFF};

  dsp_barrel_shifter dut (
    .CORE_CLK(clk), .NRST(nrst), .DMD_IN(dmd_in), .DMD_ADDR(dmd_addr), .DMD_WR(dmd_wr),
    .DMD_RD(dmd_rd), .DMD_OUT(dmd_out), .DMD_OE(dmd_oe), .R_BUS_IN(r_bus_in),
    .R_BUS_RD(r_bus_rd), .R_BUS_HIGH(r_bus_high), .R_BUS_OUT(r_bus_out), .R_BUS_OE(r_bus_oe),
    .CMD(cmd), .ALU_CARRY(alu_carry), .MODE_STATUS_REGISTER_BANK(mode_status_register_bank), .ENA_SEC(ena_sec),
    .DIS_SEC(dis_sec), .BANK_ALT(bank_alt)
  );

  core_partner partner (
    .clk(clk), .nrst(nrst), .drive(rb_drive), .value(rb_value), .r_bus(r_bus_in)
  );

  always #25 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [31:0] place_ref(input logic [15:0] v, input logic [7:0] code,
                                            input logic high, input logic ext);
    logic signed [79:0] w;
    int                 pos;
    w   = {{64{ext}}, v};
    pos = int'($signed(code)) + (high ? 16 : 0);
    if (pos >= 0)
      w = w << pos;
    else
      w = w >>> (-pos);
    return w[31:0];
  endfunction : place_ref

  function automatic logic [7:0] exp_ref(input logic [15:0] v);
    int n;
    n = 1;
    while (n < 16 && v[15-n] == v[15])
      n++;
    return 8'(1 - n);
  endfunction : exp_ref

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    checked++;
    if (seen !== expv) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  task automatic stop_test();
    $display("mismatches %0d of %0d comparisons", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  task automatic do_reset();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
  endtask : do_reset

  task automatic wr(input shifter_pkg::reg_sel_t a, input logic [15:0] d);
    @(posedge clk);
    dmd_wr   <= 1'b1;
    dmd_addr <= a;
    dmd_in   <= d;
    @(posedge clk);
    dmd_wr <= 1'b0;
  endtask : wr

  // Read with optional same-cycle write of new data
  task automatic rdc(input shifter_pkg::reg_sel_t a, input logic [15:0] expv,
                     input logic also_wr = 1'b0, input logic [15:0] d = 16'h0000);
    @(posedge clk);
    dmd_rd   <= 1'b1;
    dmd_wr   <= also_wr;
    dmd_in   <= d;
    dmd_addr <= a;
    @(posedge clk);
    dmd_rd <= 1'b0;
    dmd_wr <= 1'b0;
    @(negedge clk);
    check({dmd_oe, 15'h0000, dmd_out}, {1'b1, 15'h0000, expv});
  endtask : rdc

  task automatic rbr(input logic high, input logic [15:0] expv);
    @(posedge clk);
    r_bus_rd   <= 1'b1;
    r_bus_high <= high;
    @(posedge clk);
    r_bus_rd <= 1'b0;
    @(negedge clk);
    check({r_bus_oe, 15'h0000, r_bus_out}, {1'b1, 15'h0000, expv});
  endtask : rbr

  task automatic op(input shifter_pkg::shift_cmd_t c, input logic carry, input logic [15:0] rv);
    @(posedge clk);
    cmd       <= c;
    alu_carry <= carry;
    rb_value  <= rv;
    rb_drive  <= (c.src == shifter_pkg::SRC_RBUS);
    @(posedge clk);
    cmd.op   <= shifter_pkg::OP_NONE;
    rb_drive <= 1'b0;
  endtask : op

  task automatic bank(input logic ena, input logic dis, input logic mode, input logic expv);
    @(posedge clk);
    ena_sec    <= ena;
    dis_sec    <= dis;
    mode_status_register_bank <= mode;
    @(posedge clk);
    ena_sec <= 1'b0;
    dis_sec <= 1'b0;
    @(negedge clk);
    check({31'h0, bank_alt}, {31'h0, expv});
  endtask : bank

  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      err_total++;
      stop_test();
    end
  end

  initial begin
    shifter_pkg::shift_cmd_t c;
    logic [31:0]             r;
    logic [31:0]             r2;
    logic [31:0]             expv;
    logic [15:0]             v;
    logic [7:0]              code;
    logic [7:0]              e;
    logic [4:0]              blk_max;
    logic                    ext;
    {clk, nrst, dmd_wr, dmd_rd, r_bus_rd, r_bus_high, alu_carry} = '0;
    {mode_status_register_bank, ena_sec, dis_sec, rb_drive} = '0;
    {dmd_in, rb_value, err_total, checked, cycles} = '0;
    dmd_addr = shifter_pkg::REG_SI;
    cmd      = '0;
    seed     = 32'he4780ead;
    do_reset();
    check({31'h0, bank_alt}, 32'h0);
    for (int a = 0; a < 8; a++)
      rdc(shifter_pkg::reg_sel_t'(a), 16'h0000);
    wr(shifter_pkg::reg_sel_t'(3'h6), 16'hFFFF);
    rdc(shifter_pkg::reg_sel_t'(3'h6), 16'h0000);
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      wr(shifter_pkg::REG_SE, r[15:0]);
      rdc(shifter_pkg::REG_SE, {{8{r[7]}}, r[7:0]});
      wr(shifter_pkg::REG_SB, r[31:16]);
      rdc(shifter_pkg::REG_SB, {{11{r[20]}}, r[20:16]});
      wr(shifter_pkg::REG_SI, r[15:0]);
      rdc(shifter_pkg::REG_SI, r[15:0], 1'b1, r[31:16]);
      rdc(shifter_pkg::REG_SI, r[31:16]);
    end
    for (int i = 0; i < 48; i++) begin
      r    = rnd();
      r2   = rnd();
      v    = r[15:0];
      code = (i < 8) ? CORNER[i] : r[23:16];
      c.op                    = shifter_pkg::OP_SHIFT;
      c.src                   = shifter_pkg::operand_src_t'(r[24]);
      c.code_src              = shifter_pkg::code_src_t'(r[26:25] % 2'd3);
      c.reference_half_select = r[27];
      c.ext_src               = shifter_pkg::ext_src_t'(r[29:28] % 2'd3);
      c.or_with_result_option = r[30];
      c.imm = (c.code_src == shifter_pkg::CODE_IMM) ? code : ~code;
      if (c.code_src == shifter_pkg::CODE_SE)
        wr(shifter_pkg::REG_SE, {8'h00, code});
      if (c.code_src == shifter_pkg::CODE_NEG_SE)
        wr(shifter_pkg::REG_SE, {8'h00, 8'(-code)});
      wr(shifter_pkg::REG_SI, c.src == shifter_pkg::SRC_RBUS ? ~v : v);
      wr(shifter_pkg::REG_SR0, r2[15:0]);
      wr(shifter_pkg::REG_SR1, r2[31:16]);
      ext  = c.ext_src == shifter_pkg::EXT_MSB ? v[15] : (c.ext_src == shifter_pkg::EXT_CARRY) & r[31];
      expv = place_ref(v, code, c.reference_half_select, ext) | (r[30] ? r2 : 32'h0);
      op(c, r[31], v);
      rdc(shifter_pkg::REG_SR0, expv[15:0]);
      rdc(shifter_pkg::REG_SR1, expv[31:16]);
      rbr(r[0], r[0] ? expv[31:16] : expv[15:0]);
    end
    wr(shifter_pkg::REG_SB, 16'hFFF0);
    blk_max = 5'h10;
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      v = (i < 5) ? ECORNER[i] : 16'($signed(r[15:0]) >>> r[19:16]);
      e = exp_ref(v);
      c = '0;
      c.op = shifter_pkg::OP_EXP;
      wr(shifter_pkg::REG_SI, v);
      op(c, 1'b0, 16'h0000);
      rdc(shifter_pkg::REG_SE, {{8{e[7]}}, e});
      c.op                    = shifter_pkg::OP_SHIFT;
      c.code_src              = shifter_pkg::CODE_SE;
      c.reference_half_select = 1'b1;
      op(c, 1'b0, 16'h0000);
      expv = place_ref(v, e, 1'b1, v[15]);
      rdc(shifter_pkg::REG_SR1, expv[31:16]);
      c.op = shifter_pkg::OP_BLOCK_EXP;
      op(c, 1'b0, 16'h0000);
      if ($signed(e[4:0]) > $signed(blk_max))
        blk_max = e[4:0];
      rdc(shifter_pkg::REG_SB, {{11{blk_max[4]}}, blk_max});
    end
    wr(shifter_pkg::REG_SI, 16'h1234);
    bank(1'b1, 1'b0, 1'b0, 1'b1);
    rdc(shifter_pkg::REG_SI, 16'h0000);
    wr(shifter_pkg::REG_SI, 16'hABCD);
    bank(1'b0, 1'b1, 1'b0, 1'b0);
    rdc(shifter_pkg::REG_SI, 16'h1234);
    bank(1'b0, 1'b0, 1'b1, 1'b1);
    rdc(shifter_pkg::REG_SI, 16'hABCD);
    bank(1'b0, 1'b0, 1'b0, 1'b0);
    bank(1'b1, 1'b0, 1'b0, 1'b1);
    do_reset();
    check({31'h0, bank_alt}, 32'h0);
    rdc(shifter_pkg::REG_SI, 16'h0000);
    stop_test();
  end
endmodule : dsp_barrel_shifter_bench
